// ===== hw/cof_option_regs.sv
/*
 * Charger option register bank with its serial management bus slave.
 * Holds both option registers, runs the learn cycle and boost exits,
 * and drives the switch, monitor and charge controls to the analog side.
 * Assumes an open-drain bus resolved outside and no clock stretching.
 */
module cof_option_regs #(
    parameter logic [6:0] DEV_ADDR = cof_pkg::DEFAULT_DEV_ADDR
) (
    input  wire logic          i_clk,                    // 250 MHz clock
    input  wire logic          i_rst,                    // async reset, high
    input  wire logic          i_scl,                    // bus clock pin
    input  wire logic          i_sda,                    // bus data pin in
    output logic               o_sda,                    // bus data pin out
    output logic               o_sda_oe,                 // bus data enable
    input  wire logic          i_battery_present_n,      // battery absent high
    input  wire logic          i_battery_below_threshold, // depletion compare
    input  wire logic          i_adapter_present,        // adapter is valid
    input  wire logic          i_boost_request,          // boost wanted
    input  wire logic          i_charge_setting_valid,   // current, volt ok
    output cof_pkg::cof_ctrl_type o_ctrl                 // analog controls
);
    import cof_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [3:0] pins;
    logic       scl;
    logic       sda;
    logic       absent;
    logic       depleted;

    cof_sync #(
        .W    (4),
        .INIT (4'hf)
    ) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_scl, i_sda, i_battery_present_n,
                 i_battery_below_threshold}),
        .o_q   (pins)
    );

    assign scl      = pins[3];
    assign sda      = pins[2];
    assign absent   = pins[1];
    assign depleted = pins[0];

    cof_state_type st;
    cof_state_type next_st;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl & ~st.scl_q;
    assign scl_fall  = ~scl & st.scl_q;
    assign bus_start = scl & st.scl_q & st.sda_q & ~sda;
    assign bus_stop  = scl & st.scl_q & ~st.sda_q & sda;

    // ==========================================================
    // Register read decode
    // ==========================================================
    function automatic logic [15:0] cof_read_reg(
        input logic [7:0]  cmd,
        input logic [15:0] first,
        input logic [15:0] second
    );
        logic [15:0] val;
        val = 16'h0000;
        case (cmd)
            CMD_OPTIONS_FIRST:  val = first & MASK_FIRST;
            CMD_OPTIONS_SECOND: val = second & MASK_SECOND;
            default:            val = 16'h0000;
        endcase
        return val;
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        logic        wr_en;
        logic [15:0] wr_data;
        logic        learn;
        logic [15:0] rd_val;
        wr_en   = 1'b0;
        wr_data = 16'h0000;
        learn   = 1'b0;
        rd_val  = cof_read_reg(st.cmd, st.opt_first, st.opt_second);
        next_st = st;
        next_st.scl_q = scl;
        next_st.sda_q = sda;

        if (bus_start)
        begin
            next_st.smb     = SMB_ADDR;
            next_st.cnt     = 4'h0;
            next_st.sda_drv = 1'b0;
        end
        else if (bus_stop)
        begin
            next_st.smb     = SMB_IDLE;
            next_st.sda_drv = 1'b0;
        end
        else
        begin
            case (st.smb)
                SMB_ADDR, SMB_CMD, SMB_WLO, SMB_WHI:
                begin
                    if (scl_rise && st.cnt != BYTE_BITS)
                    begin
                        next_st.shift = {st.shift[6:0], sda};
                        next_st.cnt   = st.cnt + 4'h1;
                    end
                    else if (scl_fall && st.cnt == BYTE_BITS)
                    begin
                        next_st.cnt     = 4'h0;
                        next_st.sda_drv = 1'b1;
                        case (st.smb)
                            SMB_ADDR:
                            begin
                                if (st.shift[7:1] == DEV_ADDR)
                                begin
                                    next_st.read    = st.shift[0];
                                    next_st.hi_byte = 1'b0;
                                    next_st.txs     = {rd_val[7:0],
                                                       rd_val[15:8]};
                                    next_st.smb     = SMB_ADDR_ACK;
                                end
                                else
                                begin
                                    next_st.sda_drv = 1'b0;
                                    next_st.smb     = SMB_WAIT;
                                end
                            end
                            SMB_CMD:
                            begin
                                next_st.cmd = st.shift;
                                next_st.smb = SMB_CMD_ACK;
                            end
                            SMB_WLO:
                            begin
                                next_st.wlo = st.shift;
                                next_st.smb = SMB_WLO_ACK;
                            end
                            default:
                            begin
                                wr_en       = 1'b1;
                                wr_data     = {st.shift, st.wlo};
                                next_st.smb = SMB_WHI_ACK;
                            end
                        endcase
                    end
                end
                SMB_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (st.read)
                        begin
                            next_st.sda_drv = ~st.txs[15];
                            next_st.txs     = {st.txs[14:0], 1'b0};
                            next_st.cnt     = 4'h1;
                            next_st.smb     = SMB_TX;
                        end
                        else
                        begin
                            next_st.sda_drv = 1'b0;
                            next_st.smb     = SMB_CMD;
                        end
                    end
                end
                SMB_CMD_ACK, SMB_WLO_ACK, SMB_WHI_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_st.sda_drv = 1'b0;
                        case (st.smb)
                            SMB_CMD_ACK: next_st.smb = SMB_WLO;
                            SMB_WLO_ACK: next_st.smb = SMB_WHI;
                            default:     next_st.smb = SMB_WAIT;
                        endcase
                    end
                end
                SMB_TX:
                begin
                    if (scl_fall)
                    begin
                        if (st.cnt == BYTE_BITS)
                        begin
                            next_st.sda_drv = 1'b0;
                            next_st.cnt     = 4'h0;
                            next_st.smb     = SMB_TX_ACK;
                        end
                        else
                        begin
                            next_st.sda_drv = ~st.txs[15];
                            next_st.txs     = {st.txs[14:0], 1'b0};
                            next_st.cnt     = st.cnt + 4'h1;
                        end
                    end
                end
                SMB_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        next_st.master_ack = ~sda;
                    end
                    else if (scl_fall)
                    begin
                        if (st.master_ack && !st.hi_byte)
                        begin
                            next_st.hi_byte = 1'b1;
                            next_st.sda_drv = ~st.txs[15];
                            next_st.txs     = {st.txs[14:0], 1'b0};
                            next_st.cnt     = 4'h1;
                            next_st.smb     = SMB_TX;
                        end
                        else
                        begin
                            next_st.smb = SMB_WAIT;
                        end
                    end
                end
                SMB_IDLE, SMB_WAIT:
                begin
                    next_st.sda_drv = 1'b0;
                end
                default:
                begin
                    next_st.smb     = SMB_IDLE;
                    next_st.sda_drv = 1'b0;
                end
            endcase
        end

        // ======================================================
        // Register writes
        // ======================================================
        if (wr_en && st.cmd == CMD_OPTIONS_FIRST)
        begin
            next_st.opt_first = wr_data & MASK_FIRST;
            if (depleted)
            begin
                next_st.opt_first[POS_LEARN] = 1'b0;
            end
        end
        if (wr_en && st.cmd == CMD_OPTIONS_SECOND)
        begin
            next_st.opt_second = wr_data & MASK_SECOND;
        end

        if (absent || depleted)
        begin
            next_st.opt_first[POS_LEARN] = 1'b0;
        end
        learn = next_st.opt_first[POS_LEARN];

        // ======================================================
        // Controls to the analog side
        // ======================================================
        // learn switch pattern
        next_st.ctrl.learn_active         = learn;
        next_st.ctrl.adapter_switch       = ~learn & i_adapter_present;
        next_st.ctrl.reverse_block_switch = ~learn & i_adapter_present;
        next_st.ctrl.battery_switch       = learn | ~i_adapter_present;
        next_st.ctrl.boost_active = i_boost_request & ~depleted;
        next_st.ctrl.charge_enable = ~next_st.opt_first[POS_CHARGE_BLOCK]
                                   & i_charge_setting_valid & ~learn;
        next_st.ctrl.adapter_monitor_gain_sel =
            next_st.opt_first[POS_ADAPTER_GAIN];
        next_st.ctrl.discharge_monitor_gain_sel =
            next_st.opt_first[POS_DISCHARGE_GAIN];
        next_st.ctrl.discharge_monitor_out_en =
            next_st.opt_second[POS_DISCHARGE_OUT_EN];
        next_st.ctrl.depletion_threshold_sel =
            next_st.opt_second[POS_DEPLETION_LO +: 2];
        next_st.ctrl.sense_resistor_ratio =
            next_st.opt_second[POS_SENSE_RATIO_LO +: 2];
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st            <= '0;
            st.smb        <= SMB_IDLE;
            st.scl_q      <= 1'b1;
            st.sda_q      <= 1'b1;
            st.opt_first  <= RESET_FIRST;
            st.opt_second <= RESET_SECOND;
            st.ctrl.discharge_monitor_gain_sel <=
                RESET_FIRST[POS_DISCHARGE_GAIN];
            st.ctrl.depletion_threshold_sel <=
                RESET_SECOND[POS_DEPLETION_LO +: 2];
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_sda    = 1'b0;
    assign o_sda_oe = st.sda_drv;
    assign o_ctrl   = st.ctrl;

endmodule

// ===== hw/cof_pkg.sv
/*
 * Shared constants and types of the charger option register bank.
 * Assumes one 250 MHz clock and a serial management bus on two pins.
 */
package cof_pkg;

    // ==========================================================
    // Command codes of the two option registers
    // ==========================================================
    localparam logic [7:0]  CMD_OPTIONS_FIRST   = 8'h12;
    localparam logic [7:0]  CMD_OPTIONS_SECOND  = 8'h3b;

    // ==========================================================
    // Reset values and writable bit masks
    // ==========================================================
    localparam logic [15:0] RESET_FIRST         = 16'he108;
    localparam logic [15:0] RESET_SECOND        = 16'hc210;
    localparam logic [15:0] MASK_FIRST          = 16'he339;
    localparam logic [15:0] MASK_SECOND         = 16'hfefa;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int POS_LEARN                    = 5;
    localparam int POS_ADAPTER_GAIN             = 4;
    localparam int POS_DISCHARGE_GAIN           = 3;
    localparam int POS_CHARGE_BLOCK             = 0;
    localparam int POS_DEPLETION_LO             = 14;
    localparam int POS_SENSE_RATIO_LO           = 12;
    localparam int POS_DISCHARGE_OUT_EN         = 11;

    // ==========================================================
    // Bus framing
    // ==========================================================
    localparam logic [3:0]  BYTE_BITS           = 4'h8;
    localparam logic [6:0]  DEFAULT_DEV_ADDR    = 7'h09;

    typedef enum logic [3:0] {
        SMB_IDLE,
        SMB_ADDR,
        SMB_ADDR_ACK,
        SMB_CMD,
        SMB_CMD_ACK,
        SMB_WLO,
        SMB_WLO_ACK,
        SMB_WHI,
        SMB_WHI_ACK,
        SMB_TX,
        SMB_TX_ACK,
        SMB_WAIT
    } cof_smb_type;

    typedef struct packed {
        logic       adapter_switch;
        logic       reverse_block_switch;
        logic       battery_switch;
        logic       learn_active;
        logic       boost_active;
        logic       charge_enable;
        logic       adapter_monitor_gain_sel;
        logic       discharge_monitor_gain_sel;
        logic       discharge_monitor_out_en;
        logic [1:0] depletion_threshold_sel;
        logic [1:0] sense_resistor_ratio;
    } cof_ctrl_type;

    typedef struct packed {
        cof_smb_type  smb;
        logic [7:0]   shift;
        logic [3:0]   cnt;
        logic         read;
        logic         hi_byte;
        logic         master_ack;
        logic [7:0]   cmd;
        logic [7:0]   wlo;
        logic [15:0]  txs;
        logic         sda_drv;
        logic         scl_q;
        logic         sda_q;
        logic [15:0]  opt_first;
        logic [15:0]  opt_second;
        cof_ctrl_type ctrl;
    } cof_state_type;

endpackage

// ===== hw/cof_sync.sv
/*
 * Three-stage synchroniser with agreement filter for asynchronous pins.
 * Assumes the inputs are slow compared with the 250 MHz clock.
 */
module cof_sync #(
    parameter int             W    = 4,
    parameter logic [W-1:0]   INIT = '1
) (
    input  wire logic         i_clk,   // system clock
    input  wire logic         i_rst,   // asynchronous reset, high
    input  wire logic [W-1:0] i_d,     // asynchronous inputs
    output logic      [W-1:0] o_q      // filtered synchronous outputs
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } cof_sync_state_type;

    cof_sync_state_type st;
    cof_sync_state_type next_st;

    // A bit is taken over only once stages two and three agree.
    always_comb
    begin
        next_st    = st;
        next_st.s1 = i_d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_q = st.q;

endmodule

// ===== verif/cof_checker.sv
/*
 * Assertion checker for the charger option register bank.
 * Sees only the top module ports; bound to every instance below.
 */
module cof_checker (
    input wire logic                  i_clk,                     // clock
    input wire logic                  i_rst,                     // reset
    input wire logic                  i_scl,                     // bus clock
    input wire logic                  i_sda,                     // bus data
    input wire logic                  o_sda,                     // data out
    input wire logic                  o_sda_oe,                  // data oe
    input wire logic                  i_battery_present_n,       // absent
    input wire logic                  i_battery_below_threshold, // depleted
    input wire logic                  i_adapter_present,         // adapter
    input wire logic                  i_boost_request,           // boost
    input wire logic                  i_charge_setting_valid,    // valid
    input wire cof_pkg::cof_ctrl_type o_ctrl                     // controls
);
    timeunit 1ns;
    timeprecision 100ps;
    import cof_pkg::*;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // ==========================================================
    // Properties
    // ==========================================================
    property p_learn_switches;
        o_ctrl.learn_active |-> !o_ctrl.adapter_switch &&
            !o_ctrl.reverse_block_switch && o_ctrl.battery_switch;
    endproperty
    property p_absent_exit;
        i_battery_present_n [*8] |-> !o_ctrl.learn_active;
    endproperty
    property p_depleted_exit;
        i_battery_below_threshold [*8] |-> !o_ctrl.learn_active;
    endproperty
    property p_learn_refused;
        $rose(o_ctrl.learn_active) |-> !$past(i_battery_below_threshold, 8);
    endproperty
    property p_boost_exit;
        i_battery_below_threshold [*8] |-> !o_ctrl.boost_active;
    endproperty
    property p_boost_cause;
        o_ctrl.boost_active |-> $past(i_boost_request);
    endproperty
    property p_charge_cause;
        o_ctrl.charge_enable |->
            $past(i_charge_setting_valid) && !o_ctrl.learn_active;
    endproperty
    property p_field_timing;
        $changed({o_ctrl.adapter_monitor_gain_sel,
                  o_ctrl.discharge_monitor_gain_sel,
                  o_ctrl.discharge_monitor_out_en,
                  o_ctrl.depletion_threshold_sel,
                  o_ctrl.sense_resistor_ratio})
            |-> !i_scl && !$past(i_scl, 3);
    endproperty
    property p_ack_edge;
        $changed(o_sda_oe) |-> !i_scl;
    endproperty

    a_learn_switches: assert property (p_learn_switches)
        else $error("learn switch pattern wrong");
    a_absent_exit: assert property (p_absent_exit)
        else $error("learn kept with battery absent");
    a_depleted_exit: assert property (p_depleted_exit)
        else $error("learn kept with battery depleted");
    a_learn_refused: assert property (p_learn_refused)
        else $error("learn entered while depleted");
    a_boost_exit: assert property (p_boost_exit)
        else $error("boost kept with battery depleted");
    a_boost_cause: assert property (p_boost_cause)
        else $error("boost active without request");
    a_charge_cause: assert property (p_charge_cause)
        else $error("charge enabled without valid settings");
    a_field_timing: assert property (p_field_timing)
        else $error("option field changed outside a write");
    a_ack_edge: assert property (p_ack_edge)
        else $error("data drive changed while bus clock high");

    c_learn: cover property ($rose(o_ctrl.learn_active));
    c_boost_exit: cover property (o_ctrl.boost_active ##1
        !o_ctrl.boost_active);
    c_ack: cover property ($rose(o_sda_oe));
endmodule

bind cof_option_regs cof_checker u_chk (
    .i_clk                     (i_clk),
    .i_rst                     (i_rst),
    .i_scl                     (i_scl),
    .i_sda                     (i_sda),
    .o_sda                     (o_sda),
    .o_sda_oe                  (o_sda_oe),
    .i_battery_present_n       (i_battery_present_n),
    .i_battery_below_threshold (i_battery_below_threshold),
    .i_adapter_present         (i_adapter_present),
    .i_boost_request           (i_boost_request),
    .i_charge_setting_valid    (i_charge_setting_valid),
    .o_ctrl                    (o_ctrl)
);

// ===== verif/cof_host.sv
/*
 * Behavioural management bus host issuing write-word and read-word.
 * Assumes an open-drain data wire with pull-up resolved by the bench.
 */
module cof_host (
    input  wire logic i_clk, // pacing clock
    input  wire logic i_sda, // resolved data wire
    output logic      o_scl, // bus clock, idle high
    output logic      o_sda  // data drive, 1 releases the wire
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic hw();
        repeat (12) @(negedge i_clk);
    endtask

    // Data moves a few cycles after the clock falls so it is never
    // seen as a start or stop condition.
    task automatic bitx(input logic b, output logic r);
        o_sda = b;
        hw();
        o_scl = 1'b1;
        hw();
        r = i_sda;
        o_scl = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask

    task automatic start();
        o_sda = 1'b1;
        hw();
        o_scl = 1'b1;
        hw();
        o_sda = 1'b0;
        hw();
        o_scl = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask

    task automatic stop();
        o_sda = 1'b0;
        hw();
        o_scl = 1'b1;
        hw();
        o_sda = 1'b1;
        hw();
    endtask

    task automatic byte_x(input logic [7:0] d, input logic m,
                          output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(m, r);
        ack = ~r;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic       k0, k1, k2, k3;
        start();
        byte_x({a, 1'b0}, 1'b1, q, k0);
        byte_x(c, 1'b1, q, k1);
        byte_x(d[7:0], 1'b1, q, k2);
        byte_x(d[15:8], 1'b1, q, k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] c,
                      output logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic       k0, k1, k2, k3;
        start();
        byte_x({a, 1'b0}, 1'b1, q, k0);
        byte_x(c, 1'b1, q, k1);
        start();
        byte_x({a, 1'b1}, 1'b1, q, k2);
        byte_x(8'hff, 1'b0, q, k3);
        d[7:0] = q;
        byte_x(8'hff, 1'b1, q, k3);
        d[15:8] = q;
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule

// ===== verif/cof_option_regs_test.sv
/*
 * Self-checking bench for the charger option register bank.
 * Assumes the host model in cof_host and the bound checker.
 */
module cof_option_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cof_pkg::*;

    logic         i_clk, i_rst, scl, sda_m, sda, o_sda, o_sda_oe, ok;
    logic         present_n, below, adapter, boost, valid;
    logic [15:0]  sh1, sh2;
    cof_ctrl_type ctrl;
    int           err_count, checks_done;

    assign sda = sda_m & (o_sda_oe ? o_sda : 1'b1);

    cof_option_regs dut (
        .i_clk                     (i_clk),
        .i_rst                     (i_rst),
        .i_scl                     (scl),
        .i_sda                     (sda),
        .o_sda                     (o_sda),
        .o_sda_oe                  (o_sda_oe),
        .i_battery_present_n       (present_n),
        .i_battery_below_threshold (below),
        .i_adapter_present         (adapter),
        .i_boost_request           (boost),
        .i_charge_setting_valid    (valid),
        .o_ctrl                    (ctrl)
    );
    cof_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // ==========================================================
    // Checking and bus tasks
    // ==========================================================
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask

    function automatic logic [15:0] ectl();
        cof_ctrl_type c;
        logic         l;
        l = sh1[POS_LEARN];
        c = '{~l & adapter, ~l & adapter, l | ~adapter, l, boost & ~below,
              ~sh1[POS_CHARGE_BLOCK] & valid & ~l, sh1[POS_ADAPTER_GAIN],
              sh1[POS_DISCHARGE_GAIN], sh2[POS_DISCHARGE_OUT_EN],
              sh2[15:14], sh2[13:12]};
        return {3'h0, c};
    endfunction

    task automatic sc();
        repeat (12) @(negedge i_clk);
        chk({3'h0, ctrl}, ectl());
    endtask

    task automatic w(input logic [7:0] c, input logic [15:0] d);
        logic k;
        host.wr(DEFAULT_DEV_ADDR, c, d, k);
        chk({15'h0, k}, 16'h0001);
        if (c == CMD_OPTIONS_FIRST)
            sh1 = d & MASK_FIRST & (below ? 16'hffdf : 16'hffff);
        else
            sh2 = d & MASK_SECOND;
        sc();
    endtask

    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] v;
        logic        k;
        host.rd(DEFAULT_DEV_ADDR, c, v, k);
        chk({15'h0, k}, 16'h0001);
        chk(v, e);
    endtask

    initial
    begin
        repeat (100000) @(posedge i_clk);
        err_count++;
        $display("mismatch at %0t: run too long", $time);
        end_sim();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        i_rst = 1'b1;
        present_n = 1'b0;
        below = 1'b0;
        adapter = 1'b1;
        boost = 1'b0;
        valid = 1'b1;
        err_count = 0;
        checks_done = 0;
        sh1 = RESET_FIRST;
        sh2 = RESET_SECOND;
        repeat (3) @(negedge i_clk);
        chk({3'h0, ctrl}, 16'h002c);
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        sc();
        rdc(CMD_OPTIONS_FIRST, 16'he108);
        rdc(CMD_OPTIONS_SECOND, 16'hc210);
        w(CMD_OPTIONS_SECOND, 16'hffff);
        rdc(CMD_OPTIONS_SECOND, 16'hfefa);
        for (int k = 0; k < 4; k++)
        begin
            w(CMD_OPTIONS_SECOND, {k[1:0], k[1:0], k[0], 11'h0});
            rdc(CMD_OPTIONS_SECOND, sh2);
        end
        w(CMD_OPTIONS_FIRST, 16'hffff);
        rdc(CMD_OPTIONS_FIRST, 16'he339);
        adapter = 1'b0;
        sc();
        adapter = 1'b1;
        present_n = 1'b1;
        sh1[POS_LEARN] = 1'b0;
        sc();
        rdc(CMD_OPTIONS_FIRST, sh1);
        present_n = 1'b0;
        boost = 1'b1;
        w(CMD_OPTIONS_FIRST, 16'h0030);
        below = 1'b1;
        sh1[POS_LEARN] = 1'b0;
        sc();
        w(CMD_OPTIONS_FIRST, 16'h0020);
        rdc(CMD_OPTIONS_FIRST, 16'h0000);
        below = 1'b0;
        sc();
        valid = 1'b0;
        sc();
        valid = 1'b1;
        sc();
        w(CMD_OPTIONS_FIRST, 16'h0001);
        host.wr(7'h0a, CMD_OPTIONS_FIRST, 16'h0000, ok);
        chk({15'h0, ok}, 16'h0000);
        rdc(CMD_OPTIONS_FIRST, 16'h0001);
        rdc(8'h14, 16'h0000);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        sh1 = RESET_FIRST;
        sh2 = RESET_SECOND;
        sc();
        rdc(CMD_OPTIONS_SECOND, 16'hc210);
        end_sim();
    end
endmodule
